// ### rtl/srb_map.svh
// address map, field positions and reset values of the sensor result register bank
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH

// register indices of the output bank
`define SRB_ADDR_STATE 3'h0
`define SRB_ADDR_TEMP 3'h1
`define SRB_ADDR_CHAN_A 3'h2
`define SRB_ADDR_CHAN_B 3'h3
`define SRB_ADDR_CHAN_C 3'h4
`define SRB_ADDR_CONV_LOW 3'h5
`define SRB_ADDR_CONV_HIGH 3'h6
`define SRB_ADDR_LAST 3'h6

// bit positions inside the measurement flags byte
`define SRB_FLAG_TIME_OVF 7
`define SRB_FLAG_RES_OVF 6
`define SRB_FLAG_OVERDRIVE 5
`define SRB_FLAG_LOST 4
`define SRB_FLAG_NEW 3
`define SRB_FLAG_BUSY 2
`define SRB_FLAG_STANDBY 1
`define SRB_FLAG_POWERDOWN 0

// widths and reset values
`define SRB_TEMP_BITS 12
`define SRB_STATE_RST 8'h00
`define SRB_ZERO_BYTE 8'h00

`endif

// ### rtl/srb_pkg.sv
// types shared by the sensor result register bank
package srb_pkg;

  // register index on the byte port
  typedef logic [2:0] srb_addr_t;

  // read session tracker, open from read start until stop or end of measurement
  typedef enum logic [1:0]
  {
    SRB_IDLE = 2'b01,
    SRB_OPEN = 2'b10
  } srb_sess_e;

endpackage : srb_pkg

// ### rtl/srb_result_bank.sv
// output result register bank with buffer transfer and measurement flags
`timescale 1ns/100ps
`include "srb_map.svh"

module srb_result_bank
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // device state
  input wire logic meas_active,
  input wire logic busy,
  input wire logic standby_active,
  input wire logic powerdown_active,
  // byte port from the serial interface engine
  input wire logic i2c_rd_start,
  input wire srb_pkg::srb_addr_t i2c_addr,
  input wire logic i2c_rd_byte,
  input wire logic i2c_stop,
  input wire logic i2c_wr,
  input wire logic [7:0] i2c_wdata,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // results from the measurement sequencer
  input wire logic buf_load,
  input wire logic [11:0] buf_temp,
  input wire logic [15:0] buf_chan_a,
  input wire logic [15:0] buf_chan_b,
  input wire logic [15:0] buf_chan_c,
  input wire logic [23:0] buf_conv_ref,
  input wire logic buf_time_ovf,
  input wire logic buf_res_ovf,
  input wire logic buf_overdrive,
  // pins and state outputs
  output logic ready_out,
  output logic [7:0] operating_state_byte
);
  import srb_pkg::*;

  // true for any index inside the output bank
  function automatic logic is_bank(input srb_addr_t a);
    is_bank = (a <= `SRB_ADDR_LAST);
  endfunction : is_bank

  // true for the three channel result indices
  function automatic logic is_chan(input srb_addr_t a);
    is_chan = (a == `SRB_ADDR_CHAN_A) || (a == `SRB_ADDR_CHAN_B) || (a == `SRB_ADDR_CHAN_C);
  endfunction : is_chan

  // buffer registers
  logic [11:0] bt_r;
  logic [15:0] ba_r, bb_r, bc_r;
  logic [23:0] bv_r;
  logic [2:0] bf_r;
  logic pend_r;
  // result registers
  logic [11:0] temp_r;
  logic [15:0] chan_a_r, chan_b_r, chan_c_r;
  logic [23:0] conv_r;
  logic time_ovf_r, res_ovf_r, overdrive_r;
  logic lost_r, new_r;
  // read pointer and session
  srb_addr_t idx_r;
  logic phase_r;
  srb_sess_e sess_r;
  logic [7:0] flags_byte;
  logic [7:0] byte_mux;
  logic xfer, flags_read, chan_read;

  // ready pin is high when busy is low, whether or not meas_active is set
  // ready pin drive
  assign ready_out = ~busy;

  assign flags_byte = {time_ovf_r, res_ovf_r, overdrive_r, lost_r, new_r,
                       ~ready_out, standby_active, powerdown_active};

  // transfer on read start into the bank, only outside an open read
  assign xfer = i2c_rd_start && meas_active && (sess_r == SRB_IDLE) && is_bank(i2c_addr) && pend_r;
  assign flags_read = i2c_rd_byte && meas_active && (idx_r == `SRB_ADDR_STATE) && phase_r;
  assign chan_read = i2c_rd_byte && meas_active && is_chan(idx_r);

  // read session: open at read start, closed by stop or leaving measurement
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sess_r <= SRB_IDLE;
    else
    begin
      unique case (sess_r)
        SRB_IDLE:
          if (i2c_rd_start && meas_active)
            sess_r <= SRB_OPEN;
        SRB_OPEN:
          if (i2c_stop || !meas_active)
            sess_r <= SRB_IDLE;
        default:
          sess_r <= SRB_IDLE;
      endcase
    end
  end

  // buffer capture at end of each measurement
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      bt_r <= 12'h000;
      ba_r <= 16'h0000;
      bb_r <= 16'h0000;
      bc_r <= 16'h0000;
      bv_r <= 24'h000000;
      bf_r <= 3'h0;
    end
    else if (buf_load)
    begin
      bt_r <= buf_temp;
      ba_r <= buf_chan_a;
      bb_r <= buf_chan_b;
      bc_r <= buf_chan_c;
      bv_r <= buf_conv_ref;
      bf_r <= {buf_time_ovf, buf_res_ovf, buf_overdrive};
    end
  end

  // buffer holds data not yet moved; a new load wins over the transfer
  always_ff @(posedge sys_clk)
  begin
    if (reset || !meas_active)
      pend_r <= 1'b0;
    else if (buf_load)
      pend_r <= 1'b1;
    else if (xfer)
      pend_r <= 1'b0;
  end

  // result registers load only on a transfer, never mid-read, and clear outside measurement
  always_ff @(posedge sys_clk)
  begin
    if (reset || !meas_active)
    begin
      temp_r <= 12'h000;
      chan_a_r <= 16'h0000;
      chan_b_r <= 16'h0000;
      chan_c_r <= 16'h0000;
      conv_r <= 24'h000000;
      {time_ovf_r, res_ovf_r, overdrive_r} <= 3'h0;
    end
    else if (xfer)
    begin
      temp_r <= bt_r;
      chan_a_r <= ba_r;
      chan_b_r <= bb_r;
      chan_c_r <= bc_r;
      conv_r <= bv_r;
      {time_ovf_r, res_ovf_r, overdrive_r} <= bf_r;
    end
  end

  // new-data flag, set wins over clear
  always_ff @(posedge sys_clk)
  begin
    if (reset || !meas_active)
      new_r <= 1'b0;
    else if (xfer)
      new_r <= 1'b1;
    else if (flags_read || chan_read)
      new_r <= 1'b0;
  end

  // lost-data flag, cleared only by a flags byte read or outside measurement
  always_ff @(posedge sys_clk)
  begin
    if (reset || !meas_active)
      lost_r <= 1'b0;
    else if (buf_load && pend_r && !xfer)
      lost_r <= 1'b1;
    else if (flags_read)
      lost_r <= 1'b0;
  end

  // only index zero takes a written byte
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      operating_state_byte <= `SRB_STATE_RST;
    else if (i2c_wr && (i2c_addr == `SRB_ADDR_STATE))
      operating_state_byte <= i2c_wdata;
  end

  // read pointer: two bytes per index, low byte first
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      idx_r <= `SRB_ADDR_STATE;
      phase_r <= 1'b0;
    end
    else if (i2c_rd_start)
    begin
      idx_r <= i2c_addr;
      phase_r <= 1'b0;
    end
    else if (i2c_rd_byte)
    begin
      phase_r <= ~phase_r;
      if (phase_r)
        idx_r <= idx_r + 3'h1;
    end
  end

  // byte selection from index and phase
  always_comb
  begin
    byte_mux = `SRB_ZERO_BYTE;
    unique case ({idx_r, phase_r})
      {`SRB_ADDR_STATE, 1'b0}: byte_mux = operating_state_byte;
      {`SRB_ADDR_STATE, 1'b1}: byte_mux = flags_byte;
      {`SRB_ADDR_TEMP, 1'b0}: byte_mux = temp_r[7:0];
      {`SRB_ADDR_TEMP, 1'b1}: byte_mux = {4'h0, temp_r[11:8]};
      {`SRB_ADDR_CHAN_A, 1'b0}: byte_mux = chan_a_r[7:0];
      {`SRB_ADDR_CHAN_A, 1'b1}: byte_mux = chan_a_r[15:8];
      {`SRB_ADDR_CHAN_B, 1'b0}: byte_mux = chan_b_r[7:0];
      {`SRB_ADDR_CHAN_B, 1'b1}: byte_mux = chan_b_r[15:8];
      {`SRB_ADDR_CHAN_C, 1'b0}: byte_mux = chan_c_r[7:0];
      {`SRB_ADDR_CHAN_C, 1'b1}: byte_mux = chan_c_r[15:8];
      // time reference, high word padded with zero
      {`SRB_ADDR_CONV_LOW, 1'b0}: byte_mux = conv_r[7:0];
      {`SRB_ADDR_CONV_LOW, 1'b1}: byte_mux = conv_r[15:8];
      {`SRB_ADDR_CONV_HIGH, 1'b0}: byte_mux = conv_r[23:16];
      {`SRB_ADDR_CONV_HIGH, 1'b1}: byte_mux = `SRB_ZERO_BYTE;
      default: byte_mux = `SRB_ZERO_BYTE;
    endcase
  end

  // registered read byte, zero outside measurement state
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rd_data <= `SRB_ZERO_BYTE;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= i2c_rd_byte;
      if (i2c_rd_byte)
        rd_data <= meas_active ? byte_mux : `SRB_ZERO_BYTE;
    end
  end

  // byte request at a given index and phase
  sequence s_req(srb_addr_t a, logic ph);
    i2c_rd_byte && meas_active && idx_r == a && phase_r == ph && !i2c_rd_start;
  endsequence

  property p_flags_busy;
    @(posedge sys_clk) disable iff (reset)
    s_req(`SRB_ADDR_STATE, 1'b1) |=> rd_data[`SRB_FLAG_BUSY] == $past(busy) && $past(ready_out) == !$past(busy);
  endproperty
  a_flags_busy: assert property (p_flags_busy) else $error("busy bit mismatches ready pin");

  property p_state_first;
    @(posedge sys_clk) disable iff (reset)
    s_req(`SRB_ADDR_STATE, 1'b0) |=> rd_valid && rd_data == $past(operating_state_byte);
  endproperty
  a_state_first: assert property (p_state_first) else $error("first byte at zero not state");

  property p_chan_lsb;
    @(posedge sys_clk) disable iff (reset)
    s_req(`SRB_ADDR_CHAN_A, 1'b0) |=> rd_data == $past(chan_a_r[7:0]);
  endproperty
  a_chan_lsb: assert property (p_chan_lsb) else $error("channel low byte not first");

  property p_temp_pad;
    @(posedge sys_clk) disable iff (reset)
    s_req(`SRB_ADDR_TEMP, 1'b1) |=> rd_data[7:4] == 4'h0;
  endproperty
  a_temp_pad: assert property (p_temp_pad) else $error("temperature top nibble not zero");

  property p_conv_pad;
    @(posedge sys_clk) disable iff (reset)
    s_req(`SRB_ADDR_CONV_HIGH, 1'b1) |=> rd_valid && rd_data == `SRB_ZERO_BYTE;
  endproperty
  a_conv_pad: assert property (p_conv_pad) else $error("time reference pad byte not zero");

  property p_no_read_idle;
    @(posedge sys_clk) disable iff (reset)
    i2c_rd_byte && !meas_active |=> rd_data == `SRB_ZERO_BYTE;
  endproperty
  a_no_read_idle: assert property (p_no_read_idle) else $error("data returned outside measurement");

  property p_freeze;
    @(posedge sys_clk) disable iff (reset)
    sess_r == SRB_OPEN && meas_active ##1 meas_active |-> $stable(chan_a_r) && $stable(conv_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("results changed during open read");

  property p_new_set;
    @(posedge sys_clk) disable iff (reset)
    xfer && meas_active |=> !meas_active || (new_r && chan_b_r == $past(bb_r));
  endproperty
  a_new_set: assert property (p_new_set) else $error("transfer did not raise new data");

  property p_lost_hold;
    @(posedge sys_clk) disable iff (reset)
    lost_r && meas_active && !flags_read |=> lost_r || !meas_active;
  endproperty
  a_lost_hold: assert property (p_lost_hold) else $error("lost flag cleared without flags read");

  property p_ro_write;
    @(posedge sys_clk) disable iff (reset)
    i2c_wr && i2c_addr != `SRB_ADDR_STATE |=> $stable(operating_state_byte);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to read-only index had effect");

  property p_state_write;
    @(posedge sys_clk) disable iff (reset)
    i2c_wr && i2c_addr == `SRB_ADDR_STATE |=> operating_state_byte == $past(i2c_wdata);
  endproperty
  a_state_write: assert property (p_state_write) else $error("state byte write lost");

endmodule : srb_result_bank

// ### dv/srb_host_model.sv
// byte-port host model that reads and writes the result bank
`timescale 1ns/100ps
module srb_host_model
(
  // clock
  input wire logic sys_clk,
  // request strobes
  output logic i2c_rd_start,
  output srb_pkg::srb_addr_t i2c_addr,
  output logic i2c_rd_byte,
  output logic i2c_stop,
  output logic i2c_wr,
  output logic [7:0] i2c_wdata,
  // answer
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  import srb_pkg::*;
  logic [111:0] got;
  // idle strobes at time zero
  initial
  begin
    {i2c_rd_start, i2c_rd_byte, i2c_stop, i2c_wr} = 4'h0;
    i2c_addr = 3'h0;
    i2c_wdata = 8'h00;
  end
  // open a read at an index
  task open(input srb_addr_t a);
    @(negedge sys_clk) i2c_rd_start = 1'b1;
    i2c_addr = a;
    @(negedge sys_clk) i2c_rd_start = 1'b0;
  endtask : open
  // take bytes in order, low byte of each word first
  task take(input int n);
    int j;
    got = '0;
    for (int i = 0; i < n; i++)
    begin
      // one strobe per byte, a clock edge between raise and lower
      @(negedge sys_clk) i2c_rd_byte = 1'b1;
      @(negedge sys_clk) i2c_rd_byte = 1'b0;
      j = 0;
      while (rd_valid !== 1'b1 && j < 4)
      begin
        @(negedge sys_clk) j++;
      end
      got[8*i +: 8] = (rd_valid === 1'b1) ? rd_data : 8'hxx;
    end
  endtask : take
  // stop closes the session
  task close();
    @(negedge sys_clk) i2c_stop = 1'b1;
    @(negedge sys_clk) i2c_stop = 1'b0;
  endtask : close
  // single byte write
  task write(input srb_addr_t a, input logic [7:0] d);
    @(negedge sys_clk) i2c_wr = 1'b1;
    i2c_addr = a;
    i2c_wdata = d;
    @(negedge sys_clk) i2c_wr = 1'b0;
  endtask : write
endmodule : srb_host_model

// ### dv/test_sensor_result_register_bank.sv
// self-checking bench of the sensor result register bank
`timescale 1ns/100ps
`define SRB_CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_sensor_result_register_bank;
  import srb_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic meas_active = 1'b0, busy = 1'b1, standby_active = 1'b1, powerdown_active = 1'b0;
  logic i2c_rd_start, i2c_rd_byte, i2c_stop, i2c_wr, rd_valid, buf_load = 1'b0, ready_out;
  srb_addr_t i2c_addr;
  logic [7:0] i2c_wdata, rd_data, operating_state_byte;
  logic [11:0] buf_temp = 12'h000;
  logic [15:0] buf_chan_a = 16'h0, buf_chan_b = 16'h0, buf_chan_c = 16'h0;
  logic [23:0] buf_conv_ref = 24'h0;
  logic buf_time_ovf = 1'b0, buf_res_ovf = 1'b0, buf_overdrive = 1'b0;
  int n_fail = 0;
  int checks = 0;
  // clock and design under test
  always #20 sys_clk = ~sys_clk;
  srb_result_bank srb_result_bank_inst (.sys_clk, .reset, .meas_active, .busy, .standby_active,
    .powerdown_active, .i2c_rd_start, .i2c_addr, .i2c_rd_byte, .i2c_stop, .i2c_wr, .i2c_wdata,
    .rd_data, .rd_valid, .buf_load, .buf_temp, .buf_chan_a, .buf_chan_b, .buf_chan_c, .buf_conv_ref,
    .buf_time_ovf, .buf_res_ovf, .buf_overdrive, .ready_out, .operating_state_byte);
  srb_host_model srb_host_model_inst (.sys_clk, .i2c_rd_start, .i2c_addr, .i2c_rd_byte, .i2c_stop,
    .i2c_wr, .i2c_wdata, .rd_data, .rd_valid);
  // counts, verdict and end of run
  task wrap_up();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // sequencer end of measurement with channel a value and flag bits
  task load(input logic [15:0] a, input logic [2:0] f);
    @(negedge sys_clk) buf_load = 1'b1;
    {buf_temp, buf_chan_a, buf_chan_b, buf_chan_c} = {12'habc, a, 16'h5678, 16'h9abc};
    {buf_conv_ref, buf_time_ovf, buf_res_ovf, buf_overdrive} = {24'hfedcba, f};
    @(negedge sys_clk) buf_load = 1'b0;
  endtask : load
  // whole read session with expected bytes, low byte first
  task rd(input srb_addr_t a, input int n, input logic [111:0] e);
    srb_host_model_inst.open(a);
    srb_host_model_inst.take(n);
    srb_host_model_inst.close();
    `SRB_CHK(srb_host_model_inst.got, e)
  endtask : rd
  // hang guard
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    $display("timeout");
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    rd(3'h2, 2, 112'h0);
    `SRB_CHK(ready_out, 1'b0)
    $display("test refuse done");
    @(negedge sys_clk) meas_active = 1'b1;
    srb_host_model_inst.write(3'h0, 8'ha5);
    load(16'h1234, 3'b101);
    load(16'h1234, 3'b101);
    rd(3'h0, 14, {16'h00fe, 16'hdcba, 16'h9abc, 16'h5678, 16'h1234, 16'h0abc, 16'hbea5});
    `SRB_CHK(operating_state_byte, 8'ha5)
    $display("test full bank done");
    rd(3'h0, 2, 112'ha6a5);
    srb_host_model_inst.write(3'h3, 8'hff);
    rd(3'h3, 2, 112'h5678);
    $display("test flag clear done");
    srb_host_model_inst.open(3'h2);
    load(16'h1111, 3'b101);
    load(16'h1111, 3'b101);
    srb_host_model_inst.take(2);
    `SRB_CHK(srb_host_model_inst.got, 112'h1234)
    srb_host_model_inst.close();
    rd(3'h2, 2, 112'h1111);
    rd(3'h0, 2, 112'hb6a5);
    $display("test open session done");
    @(negedge sys_clk) {busy, standby_active, powerdown_active} = 3'b001;
    rd(3'h0, 2, 112'ha1a5);
    `SRB_CHK(ready_out, 1'b1)
    load(16'h2222, 3'b000);
    rd(3'h0, 2, 112'h09a5);
    rd(3'h0, 2, 112'h01a5);
    @(negedge sys_clk) meas_active = 1'b0;
    rd(3'h0, 2, 112'h0);
    $display("test state levels done");
    wrap_up();
  end
endmodule : test_sensor_result_register_bank
